// ===== cpu_pin_model.sv
// Far-side model: the event pin and the test input pin
`timescale 1ns/1ps
module cpu_pin_model (
   input wire logic clk_i, // System clock
   output logic event_o,   // Event pin level
   output logic test_o     // Test input level
);
   initial begin
      event_o = 1'b0;
      test_o = 1'b0;
   end
   // Four clocks each way, so the synchroniser sees every edge once
   task automatic pulse(input bit which, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge clk_i);
         if (which) test_o <= 1'b1;
         else event_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         if (which) test_o <= 1'b0;
         else event_o <= 1'b0;
      end
   endtask
endmodule

// ===== test_timer_event_standby_ctrl.sv
// Self-checking bench for the timer, test flags and standby control
`timescale 1ns/1ps
module test_timer_event_standby_ctrl;
   import tmr_pkg::*;
   logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, evt, tst, c;
   logic cpu_clk_o, osc_run_o, core_reset_o, halted_o, stopped_o;
   logic [7:0] adr_i;
   logic [7:0] k;
   logic [31:0] dat_i, dat_o;
   logic [3:0] sel_i;
   logic [32:0] notes[$];
   int mismatches = 0;
   int checks_done = 0;

   timer_event_standby_ctrl uut (.clk_i(clk_i), .rst_i(rst_i),
      .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .event_input_pin_i(evt), .ext_test_input_i(tst),
      .cpu_clk_o(cpu_clk_o), .osc_run_o(osc_run_o),
      .core_reset_o(core_reset_o), .halted_o(halted_o),
      .stopped_o(stopped_o));
   cpu_pin_model far (.clk_i(clk_i), .event_o(evt), .test_o(tst));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One classic cycle; a read notes its expected word for the monitor
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e);
      notes.push_back({~w, e});
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'h1;
      adr_i <= a;
      dat_i <= d;
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && notes.size() > 0) begin
         if (notes[0][32]) cmp(dat_o, notes[0][31:0]);
         void'(notes.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end

   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      dat_i = 32'h0;
      sel_i = 4'h1;
      k = 8'($urandom(32'h440a76da));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, OFF_MODE, 0, 32'h0);
      bus(0, OFF_COUNT, 0, 32'h0);
      bus(0, OFF_STATUS, 0, 32'h0);
      bus(0, 8'h20, 0, 32'h0);
      done("reset");
      bus(1, OFF_MODE, {24'h0, L_CLKMODE, 4'h2}, 0);
      bus(1, OFF_CMD, 32'h1, 0);
      k = 8'($urandom_range(12, 1));
      far.pulse(1'b0, k);
      settle(6);
      bus(0, OFF_COUNT, 0, {24'h0, k});
      bus(0, OFF_MODE, 0, 32'h2);
      done("event");
      bus(1, OFF_MODE, {24'h0, L_CLKMODE, 4'h6}, 0);
      bus(1, OFF_CMD, 32'h1, 0);
      bus(1, OFF_CMD, 32'h2, 0);
      settle(2);
      cmp(32'(halted_o), 32'h1);
      c = cpu_clk_o;
      settle(1);
      cmp(32'(cpu_clk_o), 32'(c));
      settle(1100);
      cmp(32'(halted_o), 32'h0);
      c = ~cpu_clk_o;
      settle(1);
      cmp(32'(cpu_clk_o), 32'(c));
      bus(0, OFF_REQTEST, 0, 32'h5);
      bus(0, OFF_REQTEST, 0, 32'h0);
      settle(1100);
      bus(1, OFF_CMD, 32'h1, 0);
      bus(0, OFF_REQTEST, 0, 32'h0);
      bus(1, OFF_MODE, {24'h0, L_CLKMODE, 4'h2}, 0);
      done("overflow");
      bus(1, OFF_MODE, {24'h0, L_EXTEN, 4'h8}, 0);
      far.pulse(1'b1, 1);
      settle(6);
      bus(1, OFF_CMD, 32'h2, 0);
      settle(2);
      cmp(32'(halted_o), 32'h0);
      bus(0, OFF_REQTEST, 0, 32'h6);
      bus(1, OFF_CMD, 32'h2, 0);
      settle(2);
      cmp(32'(halted_o), 32'h1);
      far.pulse(1'b1, 1);
      settle(6);
      cmp(32'(halted_o), 32'h0);
      bus(0, OFF_REQTEST, 0, 32'h6);
      bus(1, OFF_MODE, {24'h0, L_EXTEN, 4'h0}, 0);
      far.pulse(1'b1, 1);
      settle(6);
      bus(0, OFF_REQTEST, 0, 32'h0);
      done("test input");
      bus(1, OFF_MODE, {24'h0, L_EXTEN, 4'h8}, 0);
      bus(1, OFF_CMD, 32'h4, 0);
      settle(2);
      cmp(32'({stopped_o, osc_run_o}), 32'h2);
      far.pulse(1'b1, 1);
      settle(6);
      cmp(32'(stopped_o), 32'h1);
      @(posedge clk_i);
      rst_i <= 1'b1;
      settle(2);
      cmp(32'({halted_o, stopped_o, core_reset_o}), 32'h5);
      @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      cmp(32'({halted_o, core_reset_o}), 32'h3);
      settle(2);
      cmp(32'({halted_o, core_reset_o}), 32'h0);
      bus(0, OFF_MODE, 0, 32'h0);
      bus(0, OFF_REQTEST, 0, 32'h0);
      done("stop");
      conclude();
   end
endmodule

// ===== timer_event_standby_ctrl.sv
// Timer/event counter, test request flags and standby control, Wishbone
`timescale 1ns/1ps
module timer_event_standby_ctrl
   import tmr_pkg::*;
(
   input wire logic clk_i,              // System clock
   input wire logic rst_i,              // Synchronous reset, active high
   input wire logic [7:0] adr_i,        // Wishbone byte address
   input wire logic [31:0] dat_i,       // Wishbone write data
   output logic [31:0] dat_o,           // Wishbone read data
   input wire logic we_i,               // Wishbone write enable
   input wire logic [3:0] sel_i,        // Wishbone byte selects
   input wire logic cyc_i,              // Wishbone cycle
   input wire logic stb_i,              // Wishbone strobe
   output logic ack_o,                  // Wishbone acknowledge
   input wire logic event_input_pin_i,  // External event pulses
   input wire logic ext_test_input_i,   // External test request input
   output logic cpu_clk_o,              // CPU clock, system clock / 2 in run, held in halt and stop
   output logic osc_run_o,              // Oscillator enable, low in stop
   output logic core_reset_o,           // Core reset: PC, skip flags, ports
   output logic halted_o,               // Halt mode active
   output logic stopped_o               // Stop mode active
);

   // Bus group
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic req, acc;
   logic [1:0] clk_sel_r, clk_sel_nxt;
   logic ext_input_enable_r, ext_input_enable_nxt;
   // Synchroniser group
   logic [2:0] ev_sync_r, ev_sync_nxt;
   logic [2:0] tst_sync_r, tst_sync_nxt;
   logic ev_edge, tst_edge;
   // Count group
   logic [7:0] presc_r, presc_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic pend_r, pend_nxt;
   logic count_pulse, inc, read_hold, tstart, timer_overflow_event;
   // Flag group
   req_flags_s flags_r, flags_nxt, flags_clr;
   logic any_flag;
   // Standby group
   standby_e state_r, state_nxt;
   logic rst_seen_r, rst_seen_nxt;
   logic cpu_clk_r, cpu_clk_nxt;
   logic halt_cmd, stop_cmd;

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = acc && we_i && sel_i[0] && adr_i == off;
   endfunction

   // Effects land on the edge where ack is high, as the master samples it
   assign req = cyc_i && stb_i;
   assign acc = req && ack_r;
   assign tstart = wr_hit(OFF_CMD) && dat_i[CMD_TSTART_BIT];
   assign halt_cmd = wr_hit(OFF_CMD) && dat_i[CMD_HALT_BIT];
   assign stop_cmd = wr_hit(OFF_CMD) && dat_i[CMD_STOP_BIT];
   // Hold spans the whole read so the sampled value cannot tear
   assign read_hold = req && !we_i && adr_i == OFF_COUNT;

   always_comb begin
      ack_nxt = req && !ack_r;
      dat_nxt = dat_r;
      clk_sel_nxt = clk_sel_r;
      ext_input_enable_nxt = ext_input_enable_r;
      if (req && !ack_r) begin
         dat_nxt = '0;
         case (adr_i)
            OFF_MODE: begin
               dat_nxt[EXTEN_BIT] = ext_input_enable_r;
               dat_nxt[CS_LSB+:2] = clk_sel_r;
            end
            OFF_COUNT: dat_nxt[7:0] = cnt_r;
            OFF_REQTEST: begin
               dat_nxt[1:0] = flags_r;
               dat_nxt[2] = any_flag;
            end
            OFF_STATUS: begin
               dat_nxt[0] = state_r == ST_HALT;
               dat_nxt[1] = state_r == ST_STOP;
               dat_nxt[2] = rst_seen_r;
            end
            default: dat_nxt = '0;
         endcase
      end
      if (wr_hit(OFF_MODE)) begin
         // Bit 0 of the accumulator is left for software to keep zero
         if (dat_i[MODE_L_LSB+:4] == L_CLKMODE) begin
            clk_sel_nxt = dat_i[MODE_A_LSB+CS_LSB+:2];
         end
         if (dat_i[MODE_L_LSB+:4] == L_EXTEN) begin
            ext_input_enable_nxt = dat_i[MODE_A_LSB+EXTEN_BIT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
         clk_sel_r <= CS_RST;
         ext_input_enable_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         clk_sel_r <= clk_sel_nxt;
         ext_input_enable_r <= ext_input_enable_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = dat_r;

   // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
   always_comb begin
      ev_sync_nxt = {ev_sync_r[1:0], event_input_pin_i};
      tst_sync_nxt = {tst_sync_r[1:0], ext_test_input_i};
   end

   assign ev_edge = ev_sync_r[1] && !ev_sync_r[2];
   assign tst_edge = tst_sync_r[1] && !tst_sync_r[2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_sync_r <= '0;
         tst_sync_r <= '0;
      end else begin
         ev_sync_r <= ev_sync_nxt;
         tst_sync_r <= tst_sync_nxt;
      end
   end

   // Prescaler chain and pulse selection run in halt, freeze in stop
   always_comb begin
      case (clk_sel_r)
         CS_DIV256: count_pulse = presc_r == TAP_DIV256;
         CS_EVENT: count_pulse = ev_edge;
         CS_DIV32: count_pulse = presc_r[4:0] == TAP_DIV32[4:0];
         CS_DIV4: count_pulse = presc_r[1:0] == TAP_DIV4[1:0];
         default: count_pulse = 1'b0;
      endcase
      if (state_r == ST_STOP) begin
         count_pulse = 1'b0;
      end
   end

   // A pulse arriving during a read is deferred, not dropped
   assign inc = !read_hold && (count_pulse || pend_r);
   assign timer_overflow_event = inc && cnt_r == CNT_MAX;

   always_comb begin
      presc_nxt = presc_r;
      if (state_r != ST_STOP) begin
         presc_nxt = presc_r + 8'h01;
      end
      pend_nxt = read_hold && (pend_r || count_pulse);
      cnt_nxt = cnt_r;
      if (inc) begin
         cnt_nxt = cnt_r + 8'h01;
      end
      if (tstart) begin
         cnt_nxt = CNT_RST;
         pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_r <= PRESC_RST;
         cnt_r <= CNT_RST;
         pend_r <= 1'b0;
      end else begin
         presc_r <= presc_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
      end
   end

   // A read clears only the flags software saw, a timer start also clears tmr; new sets always win
   always_comb begin
      flags_clr = '0;
      if (acc && !we_i && adr_i == OFF_REQTEST) begin
         flags_clr = dat_r[1:0];
      end
      flags_clr.tmr = flags_clr.tmr || tstart;
      flags_nxt = flags_r & ~flags_clr;
      if (timer_overflow_event) begin
         flags_nxt.tmr = 1'b1;
      end
      if (tst_edge && ext_input_enable_r) begin
         flags_nxt.ext = 1'b1;
      end
   end

   assign any_flag = flags_r.ext || flags_r.tmr;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Standby control; memory is outside this block and untouched by it
   always_comb begin
      state_nxt = state_r;
      rst_seen_nxt = 1'b0;
      if (rst_seen_r) begin
         state_nxt = ST_RUN;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (stop_cmd && !any_flag) begin
                  state_nxt = ST_STOP;
               end else if (halt_cmd && !any_flag) begin
                  state_nxt = ST_HALT;
               end
            end
            ST_HALT: begin
               if (any_flag) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_STOP: state_nxt = ST_STOP;
            default: state_nxt = ST_RUN;
         endcase
      end
      cpu_clk_nxt = cpu_clk_r;
      if (state_r == ST_RUN) begin
         cpu_clk_nxt = !cpu_clk_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Reset holds halt and restarts the oscillator; memory kept
         state_r <= ST_HALT;
         rst_seen_r <= 1'b1;
         cpu_clk_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rst_seen_r <= rst_seen_nxt;
         cpu_clk_r <= cpu_clk_nxt;
      end
   end

   assign cpu_clk_o = cpu_clk_r;
   assign osc_run_o = state_r != ST_STOP;
   assign core_reset_o = rst_seen_r;
   assign halted_o = state_r == ST_HALT;
   assign stopped_o = state_r == ST_STOP;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_wrap;
      inc && cnt_r == CNT_MAX && !tstart;
   endsequence
   sequence s_wrapped;
      cnt_r == CNT_RST && flags_r.tmr;
   endsequence

   property p_wrap;
      s_wrap |=> s_wrapped;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap lost");

   property p_tstart;
      tstart |=> cnt_r == CNT_RST && !pend_r;
   endproperty
   a_tstart: assert property (p_tstart) else $error("start no clear");

   property p_hold;
      read_hold && $past(read_hold) |-> $stable(cnt_r);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved on read");

   property p_rst;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> clk_sel_r == CS_RST && !ext_input_enable_r
         && flags_r == '0 && presc_r == PRESC_RST && halted_o;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");

   property p_stop;
      stopped_o |=> stopped_o && !osc_run_o && $stable(cnt_r);
   endproperty
   a_stop: assert property (p_stop) else $error("stop left");

   property p_halt_rel;
      halted_o && !rst_seen_r && any_flag |=> !halted_o;
   endproperty
   a_halt_rel: assert property (p_halt_rel) else $error("halt kept");

   property p_refuse;
      !halted_o && !stopped_o && !rst_seen_r && any_flag |=> !stopped_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("stop taken");

   property p_cpuclk;
      (!halted_o && !stopped_o) [*2] |=> cpu_clk_o != $past(cpu_clk_o);
   endproperty
   a_cpuclk: assert property (p_cpuclk) else $error("cpu clk idle");

   property p_gate;
      halted_o |=> $stable(cpu_clk_o);
   endproperty
   a_gate: assert property (p_gate) else $error("cpu clk in halt");

   property p_ext;
      tst_edge && ext_input_enable_r |=> flags_r.ext;
   endproperty
   a_ext: assert property (p_ext) else $error("ext flag lost");

   property p_release;
      rst_seen_r |=> !halted_o && !core_reset_o;
   endproperty
   a_release: assert property (p_release) else $error("no release");

   property p_event;
      clk_sel_r == CS_EVENT && ev_edge && !read_hold && !tstart
         && state_r != ST_STOP && cnt_r != CNT_MAX
         |=> cnt_r == $past(cnt_r) + 8'h01;
   endproperty
   a_event: assert property (p_event) else $error("event lost");

   property p_ext_off;
      tst_edge && !ext_input_enable_r && !flags_r.ext |=> !flags_r.ext;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("ext flag set");

   property p_halt_run;
      halted_o |=> presc_r != $past(presc_r);
   endproperty
   a_halt_run: assert property (p_halt_run) else $error("halt froze");

   property p_frz;
      stopped_o |=> $stable(presc_r);
   endproperty
   a_frz: assert property (p_frz) else $error("presc ran");

   // A start that meets an overflow in the same cycle loses to the set
   sequence s_start;
      tstart && !timer_overflow_event;
   endsequence
   property p_tclr;
      s_start |=> !flags_r.tmr;
   endproperty
   a_tclr: assert property (p_tclr) else $error("timer flag kept");
endmodule

// ===== tmr_pkg.sv
// Shared constants and types for the timer, test flags and standby control
package tmr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_REQTEST = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   // Port/mode write: data[3:0] is the accumulator, data[7:4] selects target
   localparam int MODE_A_LSB = 0;
   localparam int MODE_L_LSB = 4;
   localparam logic [3:0] L_CLKMODE = 4'hc;
   localparam logic [3:0] L_EXTEN = 4'hf;
   localparam int EXTEN_BIT = 3;
   localparam int CS_LSB = 1;
   // Command register bits
   localparam int CMD_TSTART_BIT = 0;
   localparam int CMD_HALT_BIT = 1;
   localparam int CMD_STOP_BIT = 2;
   // Clock select encodings
   localparam logic [1:0] CS_DIV256 = 2'h0;
   localparam logic [1:0] CS_EVENT = 2'h1;
   localparam logic [1:0] CS_DIV32 = 2'h2;
   localparam logic [1:0] CS_DIV4 = 2'h3;
   // Prescaler taps and reset values
   localparam logic [7:0] TAP_DIV4 = 8'h03;
   localparam logic [7:0] TAP_DIV32 = 8'h1f;
   localparam logic [7:0] TAP_DIV256 = 8'hff;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [1:0] CS_RST = CS_DIV256;
   typedef struct packed {
      logic ext;
      logic tmr;
   } req_flags_s;
   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP} standby_e;
endpackage
